// ---- verilog/drs_pkg.sv ----
/*
 * Shared constants and types for the receive status register group.
 * Assumes one 25 MHz clock and a host that reaches the registers over
 * the serial register port only.
 */
package drs_pkg;

    // Register addresses on the serial port
    localparam logic [5:0] ADDR_EVENTS = 6'h08;
    localparam logic [5:0] ADDR_DATA_A = 6'h09;
    localparam logic [5:0] ADDR_QUAL_A = 6'h0A;
    localparam logic [5:0] ADDR_DATA_B = 6'h0B;

    // Event register bit positions
    localparam int EV_FULL_A  = 0;
    localparam int EV_EOF_A   = 1;
    localparam int EV_FLOW_A  = 2;
    localparam int EV_VALID_A = 3;
    localparam int EV_FULL_B  = 4;
    localparam int EV_EOF_B   = 5;
    localparam int EV_FLOW_B  = 6;
    localparam int EV_VALID_B = 7;

    // Bits cleared by a read of the event register
    localparam logic [7:0] EV_COR_MASK = 8'h66;
    localparam logic [7:0] REG_RESET   = 8'h00;

    // Serial frame: first byte carries write flag and address
    localparam int         SPI_WR_BIT  = 7;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [2:0] BIT_FIRST   = 3'h0;
    localparam logic [3:0] INV_ZERO    = 4'h0;

    // Depth of the word buffer between assembler and data register
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] qual;
    } drs_word_t;

    typedef struct packed {
        logic sck;
        logic sel_n;
        logic mosi;
    } drs_spi_pins_t;

    typedef enum logic [1:0] {
        SPI_ADDR,
        SPI_DATA,
        SPI_DONE
    } drs_spi_state_t;

endpackage : drs_pkg

// ---- verilog/drs_word_buf.sv ----
/*
 * Two-entry word buffer with valid/ready on both sides.
 * Assumes both sides run on the same clock; read data come from flops.
 */
module drs_word_buf (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              in_valid,
    output logic                   in_ready_q,
    input  wire drs_pkg::drs_word_t in_word,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output drs_pkg::drs_word_t     out_word
);

    drs_pkg::drs_word_t mem_q [drs_pkg::BUF_DEPTH];
    logic               wr_ptr_q;
    logic               rd_ptr_q;
    logic [1:0]         cnt_q;
    logic [1:0]         cnt_d;
    logic               push;
    logic               pop;

    // Handshakes; ready is a flop so the source sees a clean level
    assign push      = in_valid && in_ready_q;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt_q != 2'h0);
    assign out_word  = mem_q[rd_ptr_q];
    assign cnt_d     = cnt_q + {1'b0, push} - {1'b0, pop};

    // Storage has no reset: entries are only read once written
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_word;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_q   <= 1'b0;
            rd_ptr_q   <= 1'b0;
            cnt_q      <= 2'h0;
            in_ready_q <= 1'b1;
        end else begin
            wr_ptr_q   <= wr_ptr_q ^ push;
            rd_ptr_q   <= rd_ptr_q ^ pop;
            cnt_q      <= cnt_d;
            in_ready_q <= (cnt_d != 2'(drs_pkg::BUF_DEPTH));
        end
    end

endmodule : drs_word_buf

// ---- verilog/drs_rx_status.sv ----
/*
 * Receive event/status register group for a two-channel receiver:
 * event flags, channel A byte and per-bit qualifier, serial host port.
 * Assumes the baseband strobes bits on ref_clk, channel B data path and
 * the mode/end-of-frame controls live elsewhere and arrive as levels.
 */
module drs_rx_status (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       spi_sck,
    input  wire logic       spi_sel_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso_q,
    output logic            spi_miso_oe_n_q,
    input  wire logic       rx_enable,
    input  wire logic       tx_enable,
    input  wire logic [3:0] eof_len,
    input  wire logic       cha_bit_stb,
    input  wire logic       cha_bit,
    input  wire logic       cha_bit_ok,
    output logic            cha_ready,
    input  wire logic       chb_load,
    input  wire logic       chb_all_ok,
    input  wire logic       chb_eof
);

    drs_pkg::drs_spi_pins_t pin_s1_q, pin_s2_q, pin_s3_q;
    drs_pkg::drs_spi_state_t spi_st_q;
    drs_pkg::drs_word_t     asm_word, buf_word;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  in_sr_q, out_sr_q, rd_val, ev_q, ev_d, ev_view;
    logic [5:0]  addr_now;
    logic [7:0]  dat_a_q, qual_a_q;
    logic        sck_rise, sck_fall, selected, byte_end, rd_stb;
    logic        ev_rd, a_rd, b_rd, rx_mode;
    logic        a_full_q, b_full_q, a_load, buf_valid;
    logic [2:0]  pos_q;
    logic [3:0]  inv_q;
    logic [7:0]  asm_dat_q, asm_qual_q;
    logic        begun_q, take, eof_hit, word_done;

    // Pin synchroniser; only the second and third stages are inspected
    always_ff @(posedge ref_clk) begin
        pin_s1_q <= '{sck: spi_sck, sel_n: spi_sel_n, mosi: spi_mosi};
        pin_s2_q <= pin_s1_q;
        pin_s3_q <= pin_s2_q;
    end

    // Edge and frame decode of the serial port
    assign selected = !pin_s2_q.sel_n;
    assign sck_rise = selected && pin_s2_q.sck && !pin_s3_q.sck;
    assign sck_fall = selected && !pin_s2_q.sck && pin_s3_q.sck;
    assign byte_end = sck_rise && (bit_cnt_q == drs_pkg::BIT_LAST);
    assign addr_now = {in_sr_q[4:0], pin_s2_q.mosi};
    // No write path exists at all, so a write frame is discarded
    assign rd_stb   = byte_end && (spi_st_q == drs_pkg::SPI_ADDR)
                      && !in_sr_q[drs_pkg::SPI_WR_BIT - 1];
    assign ev_rd    = rd_stb && (addr_now == drs_pkg::ADDR_EVENTS);
    assign a_rd     = rd_stb && (addr_now == drs_pkg::ADDR_DATA_A);
    assign b_rd     = rd_stb && (addr_now == drs_pkg::ADDR_DATA_B);

    // Receive mode gates every flag
    assign rx_mode = rx_enable && !tx_enable;
    assign ev_view = rx_mode ? ev_q : drs_pkg::REG_RESET;

    // Read mux; event value is taken before its clear lands
    assign rd_val = (addr_now == drs_pkg::ADDR_EVENTS) ? ev_view :
                    (addr_now == drs_pkg::ADDR_DATA_A) ? dat_a_q :
                    (addr_now == drs_pkg::ADDR_QUAL_A) ? qual_a_q :
                    drs_pkg::REG_RESET;

    // Serial frame: address byte, then one data byte, then ignore
    always_ff @(posedge ref_clk) begin
        if (rst || !selected) begin
            spi_st_q  <= drs_pkg::SPI_ADDR;
            bit_cnt_q <= drs_pkg::BIT_FIRST;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_end) begin
                unique case (spi_st_q)
                    drs_pkg::SPI_ADDR: spi_st_q <= drs_pkg::SPI_DATA;
                    drs_pkg::SPI_DATA: spi_st_q <= drs_pkg::SPI_DONE;
                    drs_pkg::SPI_DONE: spi_st_q <= drs_pkg::SPI_DONE;
                endcase
            end
        end
    end

    // Shift registers; MSB first, data changes on the falling edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            in_sr_q  <= drs_pkg::REG_RESET;
            out_sr_q <= drs_pkg::REG_RESET;
        end else if (sck_rise) begin
            in_sr_q  <= {in_sr_q[6:0], pin_s2_q.mosi};
            out_sr_q <= rd_stb ? rd_val : out_sr_q;
        end else if (sck_fall) begin
            out_sr_q <= {out_sr_q[6:0], 1'b0};
        end
    end

    // Output pin flops; enable low while selected
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            spi_miso_q      <= 1'b0;
            spi_miso_oe_n_q <= 1'b1;
        end else begin
            spi_miso_q      <= sck_fall ? out_sr_q[7] : spi_miso_q;
            spi_miso_oe_n_q <= !selected;
        end
    end

    // Channel A bit assembly; bits before the first valid one are idle
    assign take      = cha_bit_stb && rx_mode && (begun_q || cha_bit_ok);
    assign eof_hit   = take && !cha_bit_ok && (inv_q >= eof_len);
    assign word_done = take && (eof_hit || (pos_q == drs_pkg::BIT_LAST));
    // Bit lands at its arrival position
    always_comb begin
        asm_word.data         = asm_dat_q;
        asm_word.qual         = asm_qual_q;
        asm_word.data[pos_q]  = cha_bit;
        asm_word.qual[pos_q]  = cha_bit_ok;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !rx_mode || word_done) begin
            pos_q      <= drs_pkg::BIT_FIRST;
            asm_dat_q  <= drs_pkg::REG_RESET;
            asm_qual_q <= drs_pkg::REG_RESET;
        end else if (take) begin
            pos_q      <= pos_q + 3'h1;
            asm_dat_q  <= asm_word.data;
            asm_qual_q <= asm_word.qual;
        end
    end

    // Frame tracking: invalid run length since last valid bit
    always_ff @(posedge ref_clk) begin
        if (rst || !rx_mode || eof_hit) begin
            begun_q <= 1'b0;
            inv_q   <= drs_pkg::INV_ZERO;
        end else if (take) begin
            begun_q <= 1'b1;
            inv_q   <= cha_bit_ok ? drs_pkg::INV_ZERO : inv_q + 4'h1;
        end
    end

    // Buffer absorbs a word while the host is slow to read
    drs_word_buf u_buf (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .in_valid   (word_done),
        .in_ready_q (cha_ready),
        .in_word    (asm_word),
        .out_valid  (buf_valid),
        .out_ready  (!a_full_q),
        .out_word   (buf_word)
    );
    assign a_load = buf_valid && !a_full_q;

    // Data register A and occupancy; a read empties it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dat_a_q  <= drs_pkg::REG_RESET;
            qual_a_q <= drs_pkg::REG_RESET;
            a_full_q <= 1'b0;
            b_full_q <= 1'b0;
        end else begin
            dat_a_q  <= a_load ? buf_word.data : dat_a_q;
            qual_a_q <= a_load ? buf_word.qual : qual_a_q;
            a_full_q <= a_load || (a_full_q && !a_rd);
            b_full_q <= (rx_mode && chb_load) || (b_full_q && !b_rd);
        end
    end

    // Event flags: clears first, sets after so a set wins
    // Flags consult no enable other than receive mode, so polling works
    always_comb begin
        ev_d = ev_q;
        if (ev_rd) ev_d = ev_d & ~drs_pkg::EV_COR_MASK;
        if (a_rd) ev_d[drs_pkg::EV_FULL_A] = 1'b0;
        if (b_rd) ev_d[drs_pkg::EV_FULL_B] = 1'b0;
        if (a_load) begin
            ev_d[drs_pkg::EV_FULL_A]  = 1'b1;
            ev_d[drs_pkg::EV_VALID_A] = &buf_word.qual;
        end
        if (chb_load) begin
            ev_d[drs_pkg::EV_FULL_B]  = 1'b1;
            ev_d[drs_pkg::EV_VALID_B] = chb_all_ok;
        end
        // Overflow: assembled word has nowhere to go; underflow: read of an empty data register
        if ((word_done && !cha_ready) || (a_rd && !a_full_q))
            ev_d[drs_pkg::EV_FLOW_A] = 1'b1;
        if ((chb_load && b_full_q && !b_rd) || (b_rd && !b_full_q))
            ev_d[drs_pkg::EV_FLOW_B] = 1'b1;
        if (eof_hit) ev_d[drs_pkg::EV_EOF_A] = 1'b1;
        if (chb_eof) ev_d[drs_pkg::EV_EOF_B] = 1'b1;
        if (!rx_mode) ev_d = drs_pkg::REG_RESET;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) ev_q <= drs_pkg::REG_RESET;
        else     ev_q <= ev_d;
    end

    // Checks on the logic above
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_rx_off;
        !rx_mode |=> (ev_q == drs_pkg::REG_RESET);
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("flags not zero outside receive mode");

    property p_full_a;
        (a_load && rx_mode) |=> ev_q[drs_pkg::EV_FULL_A] && a_full_q;
    endproperty
    a_full_a: assert property (p_full_a)
        else $error("full A not set on load");

    property p_valid_a;
        (a_load && rx_mode) |=>
            ev_q[drs_pkg::EV_VALID_A] == (&$past(buf_word.qual));
    endproperty
    a_valid_a: assert property (p_valid_a)
        else $error("valid A does not match loaded qualifier");

    property p_flow_a;
        (word_done && !cha_ready && rx_mode) |=> ev_q[drs_pkg::EV_FLOW_A];
    endproperty
    a_flow_a: assert property (p_flow_a)
        else $error("overflow A not flagged");

    property p_flow_b;
        (b_rd && !b_full_q && rx_mode) |=> ev_q[drs_pkg::EV_FLOW_B];
    endproperty
    a_flow_b: assert property (p_flow_b)
        else $error("underflow B not flagged");

    property p_eof_zero;
        (take && !cha_bit_ok && eof_len == 4'h0) |=>
            ev_q[drs_pkg::EV_EOF_A] && !begun_q;
    endproperty
    a_eof_zero: assert property (p_eof_zero)
        else $error("length zero end-of-frame missed");

    property p_cor_wins;
        (ev_rd && eof_hit) |=> ev_q[drs_pkg::EV_EOF_A];
    endproperty
    a_cor_wins: assert property (p_cor_wins)
        else $error("event lost under coincident read");

    property p_cor_clears;
        (ev_rd && rx_mode && !chb_eof) ##1 rx_mode
            |-> !ev_q[drs_pkg::EV_EOF_B];
    endproperty
    a_cor_clears: assert property (p_cor_clears)
        else $error("end-of-frame B not cleared by read");

    // An empty read that meets a load refills at once, so it is left out
    property p_read_empties;
        (a_rd && !a_load) |=> !a_full_q && !ev_q[drs_pkg::EV_FULL_A];
    endproperty
    a_read_empties: assert property (p_read_empties)
        else $error("data A read did not empty register");

endmodule : drs_rx_status

// ---- verif/drs_host_model.sv ----
/*
 * Host model: drives serial register frames on the select/clock/data pins.
 * Assumes mode 0 framing with write flag in bit 7 of the first byte and a
 * 320 ns serial clock that stands low outside frames.
 */
module drs_host_model (
    output drs_pkg::drs_spi_pins_t pins,
    input  wire logic              miso,
    input  wire logic              miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: deselected, clock parked low
    initial begin
        pins = '{sck: 1'b0, sel_n: 1'b1, mosi: 1'b0};
    end

    // One frame; the long low phase gives miso time to settle before sampling
    task automatic xfer(input logic [7:0] b0, input logic [7:0] b1,
                        output logic [7:0] rd);
        logic [15:0] sh;
        sh = {b0, b1};
        rd = 8'h00;
        #7;
        pins.sel_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            pins.mosi = sh[i];
            #180;
            pins.sck = 1'b1;
            if (i < 8) begin
                rd = {rd[6:0], (miso_oe_n === 1'b0) ? miso : 1'bx};
            end
            #140;
            pins.sck = 1'b0;
        end
        #160;
        pins.sel_n = 1'b1;
        pins.mosi  = ~pins.mosi; // Released line shows no stale level
        #200;
    endtask : xfer
endmodule : drs_host_model

// ---- verif/drs_rx_status_tb.sv ----
/*
 * Self-checking bench for the receive status register group.
 * Assumes the host model file and the design package are compiled first.
 */
module drs_rx_status_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0]  n;
        logic [11:0] bits;
        logic [11:0] oks;
        logic [3:0]  eof;
        logic [7:0]  data;
        logic [7:0]  mask;
        logic [7:0]  qual;
        logic [7:0]  ev;
    } drs_row_t;

    localparam logic [5:0] EV = drs_pkg::ADDR_EVENTS;
    localparam logic [5:0] DA = drs_pkg::ADDR_DATA_A;
    localparam logic [5:0] QA = drs_pkg::ADDR_QUAL_A;
    localparam logic [5:0] DB = drs_pkg::ADDR_DATA_B;

    logic                  ref_clk     = 1'b0;
    logic                  rst         = 1'b1;
    logic                  rx_enable   = 1'b1;
    logic                  tx_enable   = 1'b0;
    logic [3:0]            eof_len     = 4'h0;
    logic                  cha_bit_stb = 1'b0;
    logic                  cha_bit     = 1'b0;
    logic                  cha_bit_ok  = 1'b0;
    logic                  chb_load    = 1'b0;
    logic                  chb_all_ok  = 1'b0;
    logic                  chb_eof     = 1'b0;
    logic                  miso;
    logic                  oe_n;
    logic                  cha_ready;
    logic [7:0]            v;
    int                    n_errors        = 0;
    int                    samples_checked = 0;
    drs_pkg::drs_spi_pins_t pins;

    // Strobes, bit values, qualifiers, length, then expected reads
    drs_row_t rows [5] = '{
        '{4'h8, 12'h0A5, 12'h0FF, 4'h0, 8'hA5, 8'hFF, 8'hFF, 8'h09},
        '{4'hA, 12'h0F3, 12'h3FC, 4'h0, 8'h3C, 8'hFF, 8'hFF, 8'h09},
        '{4'h4, 12'h00D, 12'h007, 4'h0, 8'h0D, 8'h0F, 8'h07, 8'h03},
        '{4'h5, 12'h002, 12'h003, 4'h2, 8'h02, 8'h1F, 8'h03, 8'h03},
        '{4'h8, 12'h0C3, 12'h0FD, 4'h1, 8'hC3, 8'hFF, 8'hFD, 8'h01}};
    logic [7:0] ovf [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic [5:0] addrs [4] = '{EV, DA, QA, 6'h3F};

    // 25 MHz system clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    drs_rx_status u_dut (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .spi_sck         (pins.sck),
        .spi_sel_n       (pins.sel_n),
        .spi_mosi        (pins.mosi),
        .spi_miso_q      (miso),
        .spi_miso_oe_n_q (oe_n),
        .rx_enable       (rx_enable),
        .tx_enable       (tx_enable),
        .eof_len         (eof_len),
        .cha_bit_stb     (cha_bit_stb),
        .cha_bit         (cha_bit),
        .cha_bit_ok      (cha_bit_ok),
        .cha_ready       (cha_ready),
        .chb_load        (chb_load),
        .chb_all_ok      (chb_all_ok),
        .chb_eof         (chb_eof)
    );

    drs_host_model u_host (
        .pins      (pins),
        .miso      (miso),
        .miso_oe_n (oe_n)
    );

    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Register read over the serial port, then compare
    task automatic rc(input logic [5:0] a, input logic [7:0] exp,
                      input string name);
        logic [7:0] got;
        u_host.xfer({2'h0, a}, 8'h00, got);
        chk(name, exp, got);
    endtask : rc

    // Back-to-back channel A bit strobes, first bit in position 0
    task automatic send_bits(input logic [3:0] n, input logic [11:0] b,
                             input logic [11:0] ok);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            cha_bit_stb <= 1'b1;
            cha_bit     <= b[i];
            cha_bit_ok  <= ok[i];
        end
        @(posedge ref_clk);
        cha_bit_stb <= 1'b0;
    endtask : send_bits

    task automatic pulse_b(input logic ok, input logic eof);
        @(posedge ref_clk);
        chb_load   <= 1'b1;
        chb_all_ok <= ok;
        chb_eof    <= eof;
        @(posedge ref_clk);
        chb_load <= 1'b0;
        chb_eof  <= 1'b0;
    endtask : pulse_b

    // Leaving receive mode wipes flags and frame state between cases
    task automatic leave_rx();
        @(posedge ref_clk);
        rx_enable <= 1'b0;
        @(posedge ref_clk);
        rx_enable <= 1'b1;
    endtask : leave_rx

    // Watchdog; the sequence needs well under 0.3 ms
    initial begin
        #1000000;
        n_errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("oe_n idle", 8'h01, {7'h00, oe_n});
        foreach (addrs[i]) rc(addrs[i], drs_pkg::REG_RESET, "reset value");
        rc(EV, 8'h04, "events after empty read");
        // Ordinary channel A frames from the table
        foreach (rows[i]) begin
            @(posedge ref_clk);
            eof_len <= rows[i].eof;
            send_bits(rows[i].n, rows[i].bits, rows[i].oks);
            repeat (4) @(posedge ref_clk);
            rc(EV, rows[i].ev, "events");
            u_host.xfer({2'h0, DA}, 8'h00, v);
            chk("data_a", rows[i].data, v & rows[i].mask);
            rc(QA, rows[i].qual, "qual_a");
            leave_rx();
        end
        // Fill register and buffer with the host stalled, then overrun
        for (int k = 0; k < 3; k++) send_bits(4'h8, {4'h0, ovf[k]}, 12'h0FF);
        repeat (3) @(negedge ref_clk);
        chk("cha_ready", 8'h00, {7'h00, cha_ready});
        send_bits(4'h8, {4'h0, ovf[3]}, 12'h0FF);
        repeat (4) @(posedge ref_clk);
        rc(EV, 8'h0D, "events overrun");
        rc(EV, 8'h09, "events reread");
        for (int k = 0; k < 3; k++) begin
            rc(DA, ovf[k], "data_a drain");
        end
        u_host.xfer({2'h0, DA}, 8'h00, v);
        rc(EV, 8'h0C, "events underrun");
        @(negedge ref_clk);
        chk("cha_ready", 8'h01, {7'h00, cha_ready});
        // End-of-frame lands on the very edge of an event read; the 8th
        // serial rise reaches the design 63 clocks after the frame starts
        leave_rx();
        eof_len <= 4'h0;
        @(posedge ref_clk);
        fork
            rc(EV, 8'h00, "events at coincident read");
            begin
                repeat (61) @(posedge ref_clk);
                cha_bit_stb <= 1'b1;
                cha_bit     <= 1'b1;
                cha_bit_ok  <= 1'b1;
                @(posedge ref_clk);
                cha_bit_ok  <= 1'b0;
                @(posedge ref_clk);
                cha_bit_stb <= 1'b0;
            end
        join
        rc(EV, 8'h03, "events kept");
        // Channel B events, write refusal, clear on read
        leave_rx();
        pulse_b(1'b1, 1'b0);
        rc(EV, 8'h90, "events b");
        u_host.xfer({1'b1, 1'b0, EV}, 8'hFF, v);
        rc(EV, 8'h90, "events after write");
        pulse_b(1'b0, 1'b1);
        rc(EV, 8'h70, "events b overrun");
        rc(EV, 8'h10, "events b reread");
        rc(DB, 8'h00, "data_b");
        u_host.xfer({2'h0, DB}, 8'h00, v);
        rc(EV, 8'h40, "events b underrun");
        // Transmit mode hides receive status
        pulse_b(1'b1, 1'b1);
        @(posedge ref_clk);
        tx_enable <= 1'b1;
        rc(EV, 8'h00, "events in tx");
        @(posedge ref_clk);
        tx_enable <= 1'b0;
        // Reset in mid-run with flags pending
        pulse_b(1'b1, 1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rc(EV, 8'h00, "events after reset");
        final_report();
    end
endmodule : drs_rx_status_tb
